// ===== uhc_far_model.sv
// far-side model: serial memory reader and port power switches
`timescale 1ns/1ps
module uhc_far_model (
    input  wire logic        sys_clk,
    input  wire logic        eeprom_serial_clock_oe_n,
    input  wire logic [3:0]  lat,
    input  wire logic [32:0] img,
    input  wire logic [2:0]  ovc_fault,
    output logic             eeprom_done,
    output logic [32:0]      eeprom_image,
    output logic [2:0]       overcurrent_sense_n
);
    logic [4:0] cnt = '0;
    // memory read finishes lat+1 cycles after its clock pin is driven
    always @(posedge sys_clk)
    begin
        if (eeprom_serial_clock_oe_n) cnt <= '0;
        else if (cnt != 5'h1F) cnt <= cnt + 5'h1;
    end
    assign eeprom_done = cnt > {1'b0, lat};
    assign eeprom_image = eeprom_done ? img : ~img; // unread image shows garbage
    assign overcurrent_sense_n = ~ovc_fault;
endmodule

// ===== uhc_pkg.sv
// package of constants and carrier types for the hub strap configuration block
package uhc_pkg;

    // core clock rate and pull-up disable time
    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned PUR_TIME_US   = 3000;
    localparam int unsigned PUR_CYCLES    = (CLK_HZ / 1_000_000) * PUR_TIME_US;
    localparam int unsigned PUR_CNT_W     = 18;

    // edges after reset before the strap synchronisers hold pin values
    localparam logic [1:0]  SYNC_FILL     = 2'h2;

    // port counts
    localparam int unsigned MAX_PORTS     = 3;
    localparam logic [1:0]  PORTS_THREE   = 2'h3;
    localparam logic [1:0]  PORTS_TWO     = 2'h2;

    // pll output rate and reference rate
    localparam int unsigned PLL_REF_HZ    = 6_000_000;
    localparam int unsigned PLL_OUT_HZ    = 48_000_000;

    // nonremovable codes and device-removable field values
    localparam logic [1:0]  NR_NONE       = 2'h0;
    localparam logic [1:0]  NR_ONE        = 2'h1;
    localparam logic [1:0]  NR_TWO        = 2'h2;
    localparam logic [1:0]  NR_ALL        = 2'h3;
    localparam logic [7:0]  DR_NONE       = 8'h00;
    localparam logic [7:0]  DR_P1         = 8'h02;
    localparam logic [7:0]  DR_P12        = 8'h06;
    localparam logic [7:0]  DR_P123       = 8'h0E;
    localparam int unsigned HC_COMPOUND_BIT = 2;
    localparam logic [15:0] HC_BASE       = 16'h0000;

    // default identifiers (values arbitrary)
    localparam logic [15:0] DEF_VID       = 16'h1234;
    localparam logic [15:0] DEF_PID       = 16'h5678;

    // eeprom image layout
    localparam int unsigned EE_IMG_W      = 33;
    localparam int unsigned EE_GANG_BIT   = 32;

    // pull-up timer states
    typedef enum logic [1:0] {
        PUR_HOLD = 2'b01,
        PUR_ON   = 2'b10
    } uhc_pur_st_t;

    // strap set as caught after reset
    typedef struct packed {
        logic       eeprom_select_n;
        logic       three_port_select_n;
        logic [1:0] nonremovable_code;
        logic       clock_mode;
        logic       gang_pin;
    } uhc_straps_t;

    // descriptor fields presented to the enumeration engine
    typedef struct packed {
        logic [15:0] vendor_id;
        logic [15:0] product_id;
        logic [1:0]  port_count;
        logic [7:0]  device_removable;
        logic [15:0] hub_characteristics;
        logic        self_powered;
        logic        ganged;
    } uhc_desc_t;

endpackage

// ===== uhc_strap_config.sv
// strap sampling, descriptor fields, port power and pull-up timer of the hub
//
// Summary of operation
// - strap high: default IDs, no eeprom used
// - strap high: data pin is gang select
// - strap low: IDs and gang from eeprom
// - overcurrent drops matching port power enable
// - ganged: enables of existing ports together, any overcurrent
// - non-ganged: each port handled on its own
// - clock-mode low: core runs from pll
// - clock-mode high: direct clock, pll powered down
// - pll turns 6 MHz into 48 MHz
// - suspend gates the device clock off
// - port-count strap low three ports, high two
// - removable field zero or port1 bit
// - code 10 ports 1-2, 11 per count
// - compound bit set unless code 00
// - slew rate follows attached device speed
// - power strap picks bus or self power
// - pull-up disabled 3 ms after events
// - pull-up low until counter expires, then high
`timescale 1ns/1ps
module uhc_strap_config #(
    parameter int unsigned PUR_CYCLES = uhc_pkg::PUR_CYCLES,
    parameter int unsigned NPORTS     = uhc_pkg::MAX_PORTS
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      eeprom_select_n,
    input  wire logic                      three_port_select_n,
    input  wire logic [1:0]                nonremovable_code,
    input  wire logic                      power_source_select,
    input  wire logic                      clock_mode,
    input  wire logic                      gang_data_in,
    input  wire logic                      eeprom_done,
    input  wire logic [uhc_pkg::EE_IMG_W-1:0] eeprom_image,
    input  wire logic [NPORTS-1:0]         overcurrent_sense_n,
    input  wire logic [NPORTS-1:0]         port_power_request,
    input  wire logic [NPORTS-1:0]         port_low_speed,
    input  wire logic                      suspend_req,
    output logic                           eeprom_read_start,
    output logic                           eeprom_serial_clock_oe_n,
    output logic [NPORTS-1:0]              port_power_enable,
    output logic [NPORTS-1:0]              port_overcurrent,
    output logic [NPORTS-1:0]              port_slow_slew,
    output logic                           upstream_pullup_control,
    output logic                           pll_select,
    output logic                           pll_power_down,
    output logic                           osc_power_down,
    output logic                           core_clock_gate,
    output logic                           suspend_status_out,
    output logic                           config_valid,
    output uhc_pkg::uhc_desc_t             desc
);

    // all state in one packed struct
    typedef struct packed {
        logic [1:0]            pss_sync;
        logic [NPORTS-1:0]     oc_s1;
        logic [NPORTS-1:0]     oc_s2;
        logic [5:0]            strap_s1;
        logic [5:0]            strap_s2;
        logic                  sampled;
        logic [1:0]            fill;
        uhc_pkg::uhc_straps_t  straps;
        logic                  pss_last;
        uhc_pkg::uhc_pur_st_t  pur_st;
        logic [uhc_pkg::PUR_CNT_W-1:0] pur_cnt;
        logic                  ee_start;
        logic                  ee_loaded;
        logic [15:0]           vid;
        logic [15:0]           pid;
        logic                  ganged;
        logic [NPORTS-1:0]     pwr_en;
        logic [NPORTS-1:0]     oc_flag;
        logic [NPORTS-1:0]     slow;
        logic                  susp;
        uhc_pkg::uhc_desc_t    desc;
    } uhc_state_t;

    uhc_state_t st_r;
    uhc_state_t st_nxt;

    localparam logic [uhc_pkg::PUR_CNT_W-1:0] PUR_LAST =
        uhc_pkg::PUR_CNT_W'(PUR_CYCLES - 1);

    // next-state logic
    always_comb
    begin
        logic [NPORTS-1:0] oc_now;
        logic              any_oc;
        logic              three;
        logic [7:0]        dr;
        oc_now = '0;
        any_oc = 1'b0;
        three  = 1'b0;
        dr     = uhc_pkg::DR_NONE;
        st_nxt = st_r;

        // two-flop synchronisers for the power strap, overcurrent and strap pins
        st_nxt.pss_sync = {st_r.pss_sync[0], power_source_select};
        st_nxt.oc_s1    = ~overcurrent_sense_n;
        st_nxt.oc_s2    = st_r.oc_s1;
        st_nxt.strap_s1 = {eeprom_select_n, three_port_select_n, nonremovable_code,
                           clock_mode, gang_data_in};
        st_nxt.strap_s2 = st_r.strap_s1;

        // straps caught once after reset, once the synchronisers are filled;
        // catching earlier would take the reset zeros as strap levels
        if (!st_r.sampled)
        begin
            if (st_r.fill == uhc_pkg::SYNC_FILL)
            begin
                st_nxt.sampled  = 1'b1;
                st_nxt.straps   = st_r.strap_s2;
                st_nxt.pss_last = st_r.pss_sync[1];
            end
            else
                st_nxt.fill = st_r.fill + 2'h1;
        end

        // pull-up timer: restarts on any power strap change
        st_nxt.pss_last = st_r.sampled ? st_r.pss_sync[1] : st_nxt.pss_last;
        case (st_r.pur_st)
            uhc_pkg::PUR_HOLD:
            begin
                if (st_r.pur_cnt == PUR_LAST)
                    st_nxt.pur_st = uhc_pkg::PUR_ON;
                else
                    st_nxt.pur_cnt = st_r.pur_cnt + 1'b1;
            end
            uhc_pkg::PUR_ON:
                st_nxt.pur_st = uhc_pkg::PUR_ON;
            default:
                st_nxt.pur_st = uhc_pkg::PUR_HOLD;
        endcase
        if (st_r.sampled && (st_r.pss_sync[1] != st_r.pss_last))
        begin
            st_nxt.pur_st  = uhc_pkg::PUR_HOLD;
            st_nxt.pur_cnt = '0;
        end

        // identifier source: defaults or eeprom image
        st_nxt.ee_start = 1'b0;
        if (st_r.sampled && !st_r.ee_loaded)
        begin
            if (st_r.straps.eeprom_select_n)
            begin
                st_nxt.vid       = uhc_pkg::DEF_VID;
                st_nxt.pid       = uhc_pkg::DEF_PID;
                st_nxt.ganged    = st_r.straps.gang_pin;
                st_nxt.ee_loaded = 1'b1;
            end
            else if (eeprom_done)
            begin
                st_nxt.vid       = eeprom_image[31:16];
                st_nxt.pid       = eeprom_image[15:0];
                st_nxt.ganged    = eeprom_image[uhc_pkg::EE_GANG_BIT];
                st_nxt.ee_loaded = 1'b1;
            end
            else
                st_nxt.ee_start = ~st_r.ee_start;
        end

        // overcurrent handling and port power
        any_oc = |st_r.oc_s2;
        for (int i = 0; i < NPORTS; i++)
        begin
            if (st_r.ganged)
                oc_now[i] = any_oc;
            else
                oc_now[i] = st_r.oc_s2[i];
        end
        st_nxt.oc_flag = oc_now;
        for (int i = 0; i < NPORTS; i++)
        begin
            if (st_r.ganged)
                st_nxt.pwr_en[i] = port_power_request[0] & ~any_oc;
            else
                st_nxt.pwr_en[i] = port_power_request[i] & ~oc_now[i];
        end
        if (!st_r.ee_loaded)
            st_nxt.pwr_en = '0;
        three = ~st_r.straps.three_port_select_n;
        if (!three)
            st_nxt.pwr_en[NPORTS-1] = 1'b0;

        // slew rate follows speed of attached device
        st_nxt.slow = port_low_speed;
        st_nxt.susp = suspend_req;

        // descriptor fields
        case (st_r.straps.nonremovable_code)
            uhc_pkg::NR_NONE: dr = uhc_pkg::DR_NONE;
            uhc_pkg::NR_ONE:  dr = uhc_pkg::DR_P1;
            uhc_pkg::NR_TWO:  dr = uhc_pkg::DR_P12;
            uhc_pkg::NR_ALL:  dr = three ? uhc_pkg::DR_P123 : uhc_pkg::DR_P12;
            default:          dr = uhc_pkg::DR_NONE;
        endcase
        // ids and gang mode appear in the same cycle as config_valid
        st_nxt.desc.vendor_id        = st_nxt.vid;
        st_nxt.desc.product_id       = st_nxt.pid;
        st_nxt.desc.port_count       = three ? uhc_pkg::PORTS_THREE
                                             : uhc_pkg::PORTS_TWO;
        st_nxt.desc.device_removable = dr;
        st_nxt.desc.hub_characteristics = uhc_pkg::HC_BASE;
        st_nxt.desc.hub_characteristics[uhc_pkg::HC_COMPOUND_BIT] =
            (st_r.straps.nonremovable_code != uhc_pkg::NR_NONE);
        st_nxt.desc.self_powered     = st_r.pss_sync[1];
        st_nxt.desc.ganged           = st_nxt.ganged;
    end

    // state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r         <= '0;
            st_r.pur_st  <= uhc_pkg::PUR_HOLD;
            st_r.straps.eeprom_select_n <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // outputs
    assign eeprom_read_start        = st_r.ee_start;
    assign eeprom_serial_clock_oe_n = st_r.straps.eeprom_select_n | st_r.ee_loaded;
    assign port_power_enable        = st_r.pwr_en;
    assign port_overcurrent         = st_r.oc_flag;
    assign port_slow_slew           = st_r.slow;
    assign upstream_pullup_control  = (st_r.pur_st == uhc_pkg::PUR_ON);
    assign pll_select               = ~st_r.straps.clock_mode;
    assign pll_power_down           = st_r.straps.clock_mode;
    assign osc_power_down           = st_r.straps.clock_mode | st_r.susp;
    assign core_clock_gate          = st_r.susp;
    assign suspend_status_out       = st_r.susp;
    assign config_valid             = st_r.ee_loaded;
    assign desc                     = st_r.desc;

endmodule

// ===== uhc_strap_config_sva.sv
// assertion checker for the hub strap configuration block
`timescale 1ns/1ps
module uhc_strap_config_sva #(
    parameter int unsigned PUR_CYCLES = 20,
    parameter int unsigned NPORTS     = 3
) (
    input wire logic               sys_clk,
    input wire logic               rst,
    input wire logic               eeprom_select_n,
    input wire logic               three_port_select_n,
    input wire logic [1:0]         nonremovable_code,
    input wire logic               power_source_select,
    input wire logic               clock_mode,
    input wire logic [NPORTS-1:0]  overcurrent_sense_n,
    input wire logic [NPORTS-1:0]  port_power_enable,
    input wire logic [NPORTS-1:0]  port_overcurrent,
    input wire logic               upstream_pullup_control,
    input wire logic               pll_power_down,
    input wire logic               eeprom_serial_clock_oe_n,
    input wire logic               config_valid,
    input wire uhc_pkg::uhc_desc_t desc
);
    logic [17:0] since_r;
    logic        pss_r;
    logic [7:0]  dr_exp;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // cycles since reset or a power strap edge, saturating
    always_ff @(posedge sys_clk)
    begin
        pss_r <= power_source_select;
        if (rst || pss_r != power_source_select) since_r <= '0;
        else if (since_r != '1) since_r <= since_r + 18'h0_0001;
    end
    // removable field expected from the straps
    assign dr_exp = nonremovable_code == 2'h0 ? 8'h00 : nonremovable_code == 2'h1 ? 8'h02 :
        (nonremovable_code == 2'h2 || three_port_select_n) ? 8'h06 : 8'h0E;
    ovc_drops_power_a:
    assert property (!overcurrent_sense_n[0] [*4] |-> !port_power_enable[0] && port_overcurrent[0]) else $error("port 0 powered in overcurrent");
    gang_any_ovc_a:
    assert property ((desc.ganged && !overcurrent_sense_n[1]) [*4] |-> port_power_enable == '0) else $error("ganged overcurrent ignored");
    gang_together_a:
    assert property (config_valid && $past(config_valid) && desc.ganged && desc.port_count == uhc_pkg::PORTS_THREE |-> port_power_enable inside {'0, '1}) else $error("ganged enables split");
    port_alone_a:
    assert property ((!desc.ganged && overcurrent_sense_n[1]) [*4] |-> !port_overcurrent[1]) else $error("port 1 flagged without fault");
    port_count_a:
    assert property (config_valid |-> desc.port_count == (three_port_select_n ? 2'h2 : 2'h3)) else $error("bad port count");
    removable_a:
    assert property (config_valid |-> desc.device_removable == dr_exp) else $error("bad removable field");
    compound_bit_a:
    assert property (config_valid |-> desc.hub_characteristics[2] == (nonremovable_code != 2'h0)) else $error("bad compound bit");
    default_ids_a:
    assert property (config_valid && eeprom_select_n |-> desc.vendor_id == uhc_pkg::DEF_VID && eeprom_serial_clock_oe_n) else $error("default ids not used");
    direct_clock_a:
    assert property (config_valid |-> pll_power_down == clock_mode) else $error("pll power state wrong");
    pullup_held_a:
    assert property (upstream_pullup_control && since_r >= 18'h0_0003 |-> since_r >= PUR_CYCLES) else $error("pull-up enabled early");
    pullup_on_a:
    assert property (since_r >= PUR_CYCLES + 4 |-> upstream_pullup_control) else $error("pull-up not enabled");
endmodule
bind uhc_strap_config uhc_strap_config_sva #(.PUR_CYCLES(PUR_CYCLES), .NPORTS(NPORTS)) u_sva (.sys_clk, .rst, .eeprom_select_n, .three_port_select_n, .nonremovable_code, .power_source_select, .clock_mode, .overcurrent_sense_n, .port_power_enable, .port_overcurrent, .upstream_pullup_control, .pll_power_down, .eeprom_serial_clock_oe_n, .config_valid, .desc);

// ===== uhc_strap_config_tb.sv
// self-checking testbench of the hub strap configuration block
`timescale 1ns/1ps
module uhc_strap_config_tb;
    logic sys_clk, rst, eeprom_select_n, three_port_select_n, power_source_select, clock_mode;
    logic gang_data_in, eeprom_done, suspend_req, eeprom_read_start, eeprom_serial_clock_oe_n;
    logic upstream_pullup_control, pll_select, pll_power_down, osc_power_down, core_clock_gate;
    logic suspend_status_out, config_valid;
    logic [1:0] nonremovable_code;
    logic [3:0] lat;
    logic [32:0] ee_img, eeprom_image;
    logic [2:0] ovc_fault, overcurrent_sense_n, port_power_request, port_low_speed, pe_exp;
    logic [2:0] port_power_enable, port_overcurrent, port_slow_slew;
    uhc_pkg::uhc_desc_t desc;
    int seed, miscompares, checks_done, n, p;
    logic [31:0] r;
    uhc_strap_config #(.PUR_CYCLES(20), .NPORTS(3)) u_dut (.*);
    uhc_far_model u_far (.sys_clk, .eeprom_serial_clock_oe_n, .lat, .img(ee_img), .ovc_fault,
        .eeprom_done, .eeprom_image, .overcurrent_sense_n);
    // clock generator
    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_dr(input logic [1:0] c, input logic two);
        return c == 2'h0 ? 8'h00 : c == 2'h1 ? 8'h02 : (c == 2'h2 || two) ? 8'h06 : 8'h0E;
    endfunction
    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        miscompares++;
        report_and_stop;
    end
    // main sequence: one random strap set per pass, every nonremovable code twice
    initial
    begin
        seed = 46;
        {rst, suspend_req, ovc_fault, port_power_request, port_low_speed} = '1;
        {eeprom_select_n, three_port_select_n, power_source_select, clock_mode} = '0;
        {gang_data_in, nonremovable_code, lat, ee_img} = '0;
        ovc_fault = '0;
        suspend_req = 0;
        for (int i = 0; i < 8; i++)
        begin
            r = $random(seed);
            rst = 1;
            eeprom_select_n = i < 2 ? i[0] : r[0];
            three_port_select_n = r[1];
            nonremovable_code = i[1:0];
            clock_mode = r[4];
            gang_data_in = r[5];
            power_source_select = r[7];
            lat = r[11:8];
            ee_img = {r[6], $random(seed)};
            port_low_speed = r[18:16];
            step(20);
            rst = 0;
            step(1);
            chk(upstream_pullup_control, 0);
            step(24);
            chk(upstream_pullup_control, 1);
            n = 0;
            while (config_valid !== 1'b1 && n < 100)
            begin
                step(1);
                n++;
            end
            chk(desc.port_count, three_port_select_n ? 2 : 3);
            chk(desc.device_removable, exp_dr(i[1:0], three_port_select_n));
            chk(desc.hub_characteristics[2], i[1:0] != 0);
            chk(desc.vendor_id, eeprom_select_n ? uhc_pkg::DEF_VID : ee_img[31:16]);
            chk(desc.product_id, eeprom_select_n ? uhc_pkg::DEF_PID : ee_img[15:0]);
            chk(desc.ganged, eeprom_select_n ? gang_data_in : ee_img[32]);
            chk(desc.self_powered, power_source_select);
            chk({pll_select, pll_power_down, osc_power_down}, {!clock_mode, {2{clock_mode}}});
            chk(port_slow_slew, port_low_speed);
            suspend_req = 1;
            step(2);
            chk({suspend_status_out, core_clock_gate, osc_power_down}, 3'h7);
            chk(suspend_status_out, 1);
            suspend_req = 0;
            step(2);
            chk({suspend_status_out, core_clock_gate, osc_power_down}, {2'b00, clock_mode});
            port_power_request = r[14:12];
            step(3);
            pe_exp = (desc.ganged ? {3{r[12]}} : r[14:12]) & {!three_port_select_n, 2'b11};
            chk(port_power_enable, pe_exp);
            p = r[20] ? 1 : 0;
            ovc_fault[p] = 1;
            step(5);
            chk(port_power_enable, desc.ganged ? 3'h0 : pe_exp & ~(3'h1 << p));
            ovc_fault = '0;
            power_source_select = !power_source_select;
            step(4);
            chk(upstream_pullup_control, 0);
            step(20);
            chk(upstream_pullup_control, 1);
        end
        report_and_stop;
    end
endmodule
